// *** pkg/ssp_defines.svh ***
/*
  ssp_defines.svh: register indices, field positions, reset values and timing
  counts for the synchronous serial shift port.
  Assumes a 32-bit APB master; each register index maps to byte address 4*index.
*/
// Notes on behaviour
// R1: clock mode 00 slave, 01 master at CLK/2, 10 and 11 master at CLK.
// R2: reset selects slave mode, shift register clocked from the external clock.
// R3: master drives its own clock out; slave shifts on the received clock.
// R4: master stops after 8 shift clocks and holds the clock pin low.
// R5: slave ignores further clock edges once 8 cycles have arrived.
// R6: transfer ends after counting 8 shift-clock cycles, then completion event.
// R7: one 8-bit register shifts transmit data out and receive data in.
// R8: byte loaded from two nibbles; writing trigger one starts shifting.
// R9: serial output changes on each rising shift-clock edge.
// R10: done flag always sets; interrupt only when its enable bit is set.
// R11: sample input on rising edge if edge select is 1, else falling.
// R12: received byte is readable through the two data nibbles.
// R13: bit order bit selects LSB first or MSB first, both directions.
// R14: in slave mode ready is high only while able to transfer.
// R15: ready rises on trigger write, falls on first high clock level.
// R16: any read or write of the high nibble drives ready low.
// R17: port function bit routes the four pins to the port; cleared at reset.
// R18: reading the trigger location returns one while a transfer runs.
// R19: external master clocks only after ready, exactly eight cycles per byte.
// R20: master keeps clock low and idle until the trigger is written.
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_IDX_CTRL      8'hCC
`define SSP_IDX_CFG       8'hCD
`define SSP_IDX_DLO       8'hCE
`define SSP_IDX_DHI       8'hCF
`define SSP_IDX_IEN       8'hF0
`define SSP_IDX_FLAG      8'hF4

`define SSP_CTRL_PFS      0
`define SSP_CTRL_TRG      1
`define SSP_CFG_MODE_LO   0
`define SSP_CFG_MODE_HI   1
`define SSP_CFG_SEDGE     2
`define SSP_CFG_ORDER     3
`define SSP_IEN_BIT       1
`define SSP_FLAG_BIT      0

`define SSP_RST_MODE      2'h0
`define SSP_RST_BIT       1'h0

`define SSP_BITS          8
`define SSP_CORE_HZ       50000000
`define SSP_SYS_HZ        32768
`define SSP_HALF_FULL_CYC (`SSP_CORE_HZ / (2 * `SSP_SYS_HZ))

`endif

// *** pkg/ssp_pkg.sv ***
/*
  ssp_pkg: types shared by the serial shift port modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ssp_pkg;
  typedef enum logic [1:0] {SSP_SLAVE, SSP_MASTER_HALF, SSP_MASTER_FULL} ssp_mode_t;
  typedef enum logic {SSP_IDLE, SSP_SHIFT} ssp_state_t;
  typedef enum logic [2:0] {
    SSP_R_CTRL, SSP_R_CFG, SSP_R_DLO, SSP_R_DHI, SSP_R_IEN, SSP_R_FLAG, SSP_R_NONE
  } ssp_reg_t;
endpackage
`default_nettype wire

// *** pkg/ssp_clk_if.sv ***
/*
  ssp_clk_if: synchronised pin levels and internal clock generator control.
  Assumes all members live in the core_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface ssp_clk_if;
  logic sclk_pin_s;
  logic sin_pin_s;
  logic gen_start;
  logic gen_half;
  logic gen_level;
  logic gen_busy;
  modport sync (output sclk_pin_s, sin_pin_s);
  modport gen  (input gen_start, gen_half, output gen_level, gen_busy);
  modport core (input sclk_pin_s, sin_pin_s, gen_level, gen_busy,
                output gen_start, gen_half);
endinterface
`default_nettype wire

// *** hw/ssp_pin_sync.sv ***
/*
  ssp_pin_sync: two-flop synchronisers for the clock and data input pins.
  Assumes pins are asynchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module ssp_pin_sync
  import ssp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       sclk_pin_i,
  input  wire logic       sin_pin_i,
  ssp_clk_if.sync         cs
);
  logic [1:0] raw;
  wire  [1:0] sync_v;

  assign raw = {sclk_pin_i, sin_pin_i};

  // each stage owns its flops, so no vector has two driving processes
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      logic meta_r;
      logic sync_r;
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_r <= 1'h0;
          sync_r <= 1'h0;
        end
        else
        begin
          meta_r <= raw[g];
          sync_r <= meta_r;
        end
      end
      assign sync_v[g] = sync_r;
    end
  endgenerate

  assign cs.sclk_pin_s = sync_v[1];
  assign cs.sin_pin_s  = sync_v[0];
endmodule
`default_nettype wire

// *** hw/ssp_sclk_gen.sv ***
/*
  ssp_sclk_gen: master shift-clock generator, eight cycles per start, ends low.
  Assumes gen_start is a one-cycle pulse from the core.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module ssp_sclk_gen
  import ssp_pkg::*;
#(
  parameter logic [11:0] HALF_CYC = 12'(`SSP_HALF_FULL_CYC)
)
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  ssp_clk_if.gen          cg
);
  logic [11:0] cnt_r;
  logic [11:0] lim_r;
  logic [4:0]  tog_r;
  logic        lvl_r;
  logic        busy_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r  <= 12'h000;
      lim_r  <= 12'h000;
      tog_r  <= 5'h00;
      lvl_r  <= 1'h0;
      busy_r <= 1'h0;
    end
    else if (!busy_r && cg.gen_start)
    begin
      lim_r  <= cg.gen_half ? 12'(2 * HALF_CYC - 1) : 12'(HALF_CYC - 1);
      cnt_r  <= cg.gen_half ? 12'(2 * HALF_CYC - 1) : 12'(HALF_CYC - 1);
      tog_r  <= 5'h00;
      lvl_r  <= 1'h0;
      busy_r <= 1'h1;
    end
    else if (busy_r)
    begin
      if (cnt_r == 12'h000)
      begin
        lvl_r <= ~lvl_r;
        tog_r <= tog_r + 5'h01;
        cnt_r <= lim_r;
        // sixteenth toggle lands low and stops the clock [R4]
        if (tog_r == 5'(2 * `SSP_BITS - 1))
          busy_r <= 1'h0;
      end
      else
        cnt_r <= cnt_r - 12'h001;
    end
  end

  assign cg.gen_level = lvl_r;
  assign cg.gen_busy  = busy_r;
endmodule
`default_nettype wire

// *** hw/ssp_port.sv ***
/*
  ssp_port: 8-bit synchronous serial shift port with an APB register slave.
  Assumes a 32-bit APB master on core_clk and port pins resolved outside
  from the value/enable pairs; serial pins are asynchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module ssp_port
  import ssp_pkg::*;
#(
  parameter logic [11:0] HALF_CYC = 12'(`SSP_HALF_FULL_CYC)
)
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_pin,
  input  wire logic        sclk_pin_i,
  output logic             sclk_pin_o,
  output logic             sclk_pin_oe,
  output logic             serial_out_pin,
  output logic             serial_out_pin_oe,
  output logic             slave_ready_out,
  output logic             slave_ready_out_oe,
  output logic             transfer_irq
);
  ssp_clk_if ck ();

  ssp_pin_sync u_sync (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .sclk_pin_i (sclk_pin_i),
    .sin_pin_i  (serial_in_pin),
    .cs         (ck.sync)
  );

  ssp_sclk_gen #(.HALF_CYC(HALF_CYC)) u_gen (
    .core_clk (core_clk),
    .nrst     (nrst),
    .cg       (ck.gen)
  );

  function automatic ssp_reg_t reg_of(input logic [11:0] a);
    if (a[1:0] != 2'h0 || a[11:10] != 2'h0)
      return SSP_R_NONE;
    case (a[9:2])
      `SSP_IDX_CTRL: return SSP_R_CTRL;
      `SSP_IDX_CFG:  return SSP_R_CFG;
      `SSP_IDX_DLO:  return SSP_R_DLO;
      `SSP_IDX_DHI:  return SSP_R_DHI;
      `SSP_IDX_IEN:  return SSP_R_IEN;
      `SSP_IDX_FLAG: return SSP_R_FLAG;
      default:       return SSP_R_NONE;
    endcase
  endfunction

  function automatic ssp_mode_t mode_of(input logic [1:0] m);
    case (m)
      2'h0:    return SSP_SLAVE;
      2'h1:    return SSP_MASTER_HALF;
      default: return SSP_MASTER_FULL;
    endcase
  endfunction

  // register state
  logic       pfs_r;
  logic [1:0] mode_r;
  logic       sedge_r;
  logic       order_r;
  logic       ien_r;
  logic       flag_r;
  logic [7:0] sr_r;
  ssp_state_t st_r;
  logic [3:0] cyc_r;
  logic       serial_out_pin_r;
  logic       rdy_r;
  logic       irq_r;
  logic       lvl_q_r;
  logic       sclk_o_r;
  logic       sclk_oe_r;
  logic       serial_out_pin_oe_r;
  logic       rdy_oe_r;
  logic       pready_r;
  logic       pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // bus decode
  ssp_reg_t   sel_reg;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       trig_wr;
  logic       dhi_acc;
  logic       is_master;
  logic       run;

  // shift clock events
  logic       sel_lvl;
  logic       rise_evt;
  logic       fall_evt;
  logic       samp_evt;
  logic       done_evt;
  logic       out_bit;
  logic [7:0] sr_shift;

  assign sel_reg   = reg_of(paddr);
  assign acc       = psel && penable && pready_r;
  assign wr        = acc && pwrite;
  assign rd        = acc && !pwrite;
  assign run       = (st_r == SSP_SHIFT);
  assign trig_wr   = wr && sel_reg == SSP_R_CTRL && pwdata[`SSP_CTRL_TRG] && !run; // [R8]
  assign dhi_acc   = acc && sel_reg == SSP_R_DHI;
  assign is_master = mode_of(mode_r) != SSP_SLAVE; // [R1]

  // internal clock in master, pin clock in slave [R3]
  assign sel_lvl  = is_master ? ck.gen_level : ck.sclk_pin_s;
  assign rise_evt = run && sel_lvl && !lvl_q_r;
  assign fall_evt = run && !sel_lvl && lvl_q_r;
  assign samp_evt = sedge_r ? rise_evt : fall_evt; // [R11]
  // a cycle ends on its falling edge; the eighth ends the transfer [R6]
  assign done_evt = fall_evt && cyc_r == 4'(`SSP_BITS - 1);
  assign out_bit  = order_r ? sr_r[0] : sr_r[7]; // [R13]
  assign sr_shift = order_r ? {ck.sin_pin_s, sr_r[7:1]} : {sr_r[6:0], ck.sin_pin_s}; // [R13]

  assign ck.gen_start = trig_wr && is_master; // [R20]
  assign ck.gen_half  = mode_of(mode_r) == SSP_MASTER_HALF; // [R1]

  // apb: one wait state so read data comes from a flop
  always_comb
  begin
    prdata_nxt = 32'h0000_0000;
    case (sel_reg)
      SSP_R_CTRL:
      begin
        prdata_nxt[`SSP_CTRL_PFS] = pfs_r;
        prdata_nxt[`SSP_CTRL_TRG] = run; // [R18]
      end
      SSP_R_CFG:  prdata_nxt[3:0] = {order_r, sedge_r, mode_r};
      SSP_R_DLO:  prdata_nxt[3:0] = sr_r[3:0]; // [R12]
      SSP_R_DHI:  prdata_nxt[3:0] = sr_r[7:4]; // [R12]
      SSP_R_IEN:  prdata_nxt[`SSP_IEN_BIT] = ien_r;
      SSP_R_FLAG: prdata_nxt[`SSP_FLAG_BIT] = flag_r;
      default:    prdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready_r  <= 1'h0;
      pslverr_r <= 1'h0;
      prdata_r  <= 32'h0000_0000;
    end
    else if (psel && penable && !pready_r)
    begin
      pready_r  <= 1'h1;
      pslverr_r <= sel_reg == SSP_R_NONE;
      prdata_r  <= pwrite ? 32'h0000_0000 : prdata_nxt;
    end
    else
    begin
      pready_r  <= 1'h0;
      pslverr_r <= 1'h0;
    end
  end

  // software configuration
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pfs_r   <= `SSP_RST_BIT; // [R17]
      mode_r  <= `SSP_RST_MODE; // [R2]
      sedge_r <= `SSP_RST_BIT;
      order_r <= `SSP_RST_BIT;
      ien_r   <= `SSP_RST_BIT;
    end
    else if (wr)
    begin
      if (sel_reg == SSP_R_CTRL)
        pfs_r <= pwdata[`SSP_CTRL_PFS]; // [R17]
      if (sel_reg == SSP_R_CFG)
      begin
        mode_r  <= pwdata[`SSP_CFG_MODE_HI:`SSP_CFG_MODE_LO]; // [R1]
        sedge_r <= pwdata[`SSP_CFG_SEDGE];
        order_r <= pwdata[`SSP_CFG_ORDER];
      end
      if (sel_reg == SSP_R_IEN)
        ien_r <= pwdata[`SSP_IEN_BIT];
    end
  end

  // transfer state
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= SSP_IDLE;
    else
    begin
      case (st_r)
        SSP_IDLE:  if (trig_wr) st_r <= SSP_SHIFT; // [R8]
        SSP_SHIFT: if (done_evt) st_r <= SSP_IDLE; // [R6]
        default:   st_r <= SSP_IDLE;
      endcase
    end
  end

  // edges beyond the eighth cycle find the port idle and are dropped [R5]
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cyc_r <= 4'h0;
    else if (trig_wr)
      cyc_r <= 4'h0;
    else if (fall_evt)
      cyc_r <= cyc_r + 4'h1; // [R6]
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      lvl_q_r <= 1'h0;
    else
      lvl_q_r <= sel_lvl;
  end

  // one register both ways; nibble writes are ignored mid-transfer
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      sr_r <= 8'h00;
    else if (samp_evt)
      sr_r <= sr_shift; // [R7] [R11]
    else if (wr && !run && sel_reg == SSP_R_DLO)
      sr_r[3:0] <= pwdata[3:0]; // [R8]
    else if (wr && !run && sel_reg == SSP_R_DHI)
      sr_r[7:4] <= pwdata[3:0]; // [R8]
  end

  // taken from the pre-shift value, so a rising-edge sample never corrupts it
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      serial_out_pin_r <= 1'h0;
    else if (rise_evt)
      serial_out_pin_r <= out_bit; // [R9]
  end

  // set wins over clear-on-read; only a bit the read returned is cleared
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      flag_r <= 1'h0;
    else if (done_evt)
      flag_r <= 1'h1; // [R10]
    else if (rd && sel_reg == SSP_R_FLAG && prdata_r[`SSP_FLAG_BIT])
      flag_r <= 1'h0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      irq_r <= 1'h0;
    else
      irq_r <= flag_r && ien_r; // [R10]
  end

  // ready: slave only, up on trigger, down on first high clock or high nibble
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rdy_r <= 1'h0;
    else if (trig_wr && !is_master)
      rdy_r <= 1'h1; // [R15]
    else if (is_master || dhi_acc || (run && ck.sclk_pin_s))
      rdy_r <= 1'h0; // [R14] [R15] [R16]
  end

  // pin drivers; everything off while the pins are ordinary i/o
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_o_r  <= 1'h0;
      sclk_oe_r <= 1'h0;
      serial_out_pin_oe_r <= 1'h0;
      rdy_oe_r  <= 1'h0;
    end
    else
    begin
      sclk_o_r  <= is_master && ck.gen_level; // [R3] [R4]
      sclk_oe_r <= pfs_r && is_master; // [R17] [R3]
      serial_out_pin_oe_r <= pfs_r; // [R17]
      rdy_oe_r  <= pfs_r && !is_master; // [R17] [R14]
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign sclk_pin_o         = sclk_o_r;
  assign sclk_pin_oe        = sclk_oe_r;
  assign serial_out_pin     = serial_out_pin_r;
  assign serial_out_pin_oe  = serial_out_pin_oe_r;
  assign slave_ready_out    = rdy_r;
  assign slave_ready_out_oe = rdy_oe_r;
  assign transfer_irq       = irq_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_MASTER_IDLE_LOW: assert property ( // [R20]
    is_master && !run && !ck.gen_busy |=> !sclk_o_r)
    else $error("master clock not low while idle");
  AST_GEN_STOPS: assert property ( // [R4]
    $fell(ck.gen_busy) |-> !ck.gen_level ##1 !sclk_o_r)
    else $error("clock generator did not stop low");
  AST_CYC_BOUND: assert property ( // [R6]
    cyc_r <= 4'(`SSP_BITS))
    else $error("cycle count exceeded eight");
  AST_DONE_ENDS_RUN: assert property ( // [R6]
    done_evt |=> !run && flag_r)
    else $error("completion did not end transfer and set flag");
  AST_SLAVE_MASKED: assert property ( // [R5]
    !run && !trig_wr |=> $stable(cyc_r) && $stable(serial_out_pin_r))
    else $error("edges acted on while idle");
  AST_IRQ_MASK: assert property ( // [R10]
    !ien_r |=> !transfer_irq)
    else $error("interrupt raised while masked");
  AST_IRQ_FOLLOWS: assert property ( // [R10]
    flag_r && ien_r |=> transfer_irq)
    else $error("interrupt missing with flag and enable");
  AST_RDY_RISE: assert property ( // [R15]
    trig_wr && !is_master |=> slave_ready_out)
    else $error("ready did not rise after trigger");
  AST_RDY_HI_NIBBLE: assert property ( // [R16]
    dhi_acc |=> !slave_ready_out)
    else $error("ready still high after high nibble access");
  AST_RDY_SLAVE: assert property ( // [R14]
    slave_ready_out |-> !$past(is_master))
    else $error("ready high outside slave mode");
  AST_SERIAL_OUT_PIN_ON_RISE: assert property ( // [R9]
    $changed(serial_out_pin_r) |-> $past(rise_evt))
    else $error("serial output changed without rising edge");
  AST_STATUS_READ: assert property ( // [R18]
    trig_wr |=> run [*2])
    else $error("run status not set after trigger");
endmodule
`default_nettype wire

// *** dv/ssp_peer_model.sv ***
/*
  ssp_peer_model: far-side serial device, link master or link slave on demand.
  Assumes core_clk as its time base; lines are released to their idle levels.
*/
`timescale 1ns/1ns
`default_nettype none
module ssp_peer_model
(
  input  wire logic core_clk,
  input  wire logic sclk_line,
  input  wire logic serial_out_pin_line,
  output logic      sclk_drv,
  output logic      sin_drv
);
  logic sclk_q;

  initial
  begin
    sclk_drv = 1'b0;
    sin_drv  = 1'b0;
    sclk_q   = 1'b0;
  end

  always @(posedge core_clk) sclk_q <= sclk_line;

  function automatic int bix(input logic lsb, input int i);
    return lsb ? i : 7 - i;
  endfunction

  // link master, 160 ns period; data moves mid-phase, away from the sampled edge
  task automatic as_master(input logic [7:0] tx, input logic lsb, input logic rise,
                           input int nclk, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    for (i = 0; i <= nclk; i++)
    begin
      repeat (2) @(posedge core_clk);
      if (i > 0 && i <= 8) rx[bix(lsb, i - 1)] = serial_out_pin_line;
      if (i == nclk) break;
      if (rise) sin_drv <= (i < 8) ? tx[bix(lsb, i)] : 1'b1;
      repeat (2) @(posedge core_clk);
      sclk_drv <= 1'b1;
      repeat (2) @(posedge core_clk);
      if (!rise) sin_drv <= (i < 8) ? tx[bix(lsb, i)] : 1'b1;
      repeat (2) @(posedge core_clk);
      sclk_drv <= 1'b0;
    end
    sin_drv <= 1'b0; // pull-down once released
  endtask

  // link slave: follows the clock for a fixed window, counts its falls
  task automatic as_slave(input logic [7:0] tx, input logic lsb, input logic rise,
                          output logic [7:0] rx, output int falls, output int hi_len);
    int t;
    rx = 8'h00;
    falls = 0;
    hi_len = 0;
    if (rise) sin_drv <= tx[bix(lsb, 0)];
    for (t = 0; t < 400; t++)
    begin
      @(posedge core_clk);
      if (falls == 0 && sclk_line) hi_len++;
      if (sclk_line && !sclk_q && !rise && falls < 8) sin_drv <= tx[bix(lsb, falls)];
      if (!sclk_line && sclk_q)
      begin
        if (falls < 8) rx[bix(lsb, falls)] = serial_out_pin_line;
        falls++;
        if (rise && falls < 8) sin_drv <= tx[bix(lsb, falls)];
      end
    end
    sin_drv <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/sync_serial_shift_port_tb_top.sv ***
/*
  sync_serial_shift_port_tb_top: self-checking bench for ssp_port.
  Assumes ssp_pkg, ssp_defines.svh and ssp_peer_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module sync_serial_shift_port_tb_top;
  import ssp_pkg::*;
  localparam logic [11:0] HC = 12'h008;
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        sclk_pin_o, sclk_pin_oe, serial_out_pin, serial_out_pin_oe;
  logic        slave_ready_out, slave_ready_out_oe, transfer_irq;
  logic        peer_sclk, peer_sin;
  wire         sclk_line = sclk_pin_oe ? sclk_pin_o : peer_sclk;
  wire         serial_out_pin_line = serial_out_pin_oe ? serial_out_pin : ~serial_out_pin;
  int          errors, comparisons, cycles;

  ssp_port #(.HALF_CYC(HC)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(peer_sin),
    .sclk_pin_i(sclk_line), .sclk_pin_o(sclk_pin_o), .sclk_pin_oe(sclk_pin_oe),
    .serial_out_pin(serial_out_pin), .serial_out_pin_oe(serial_out_pin_oe),
    .slave_ready_out(slave_ready_out), .slave_ready_out_oe(slave_ready_out_oe),
    .transfer_irq(transfer_irq));

  ssp_peer_model u_peer (
    .core_clk(core_clk), .sclk_line(sclk_line), .serial_out_pin_line(serial_out_pin_line),
    .sclk_drv(peer_sclk), .sin_drv(peer_sin));

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // run is under two thousand cycles; a hang past twenty thousand is a failure
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // pready looked at on rising edges only; a hang is ended by the watchdog
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    do
      @(posedge core_clk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
  endtask

  task automatic rdc(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0, rd, err);
    check(name, rd, exp);
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    logic        err;
    rdc("cfg", `SSP_IDX_CFG, 32'h0);
    rdc("ctrl", `SSP_IDX_CTRL, 32'h0);
    check("serial_out_pin oe", 32'(serial_out_pin_oe), 32'h0);
    check("sclk oe", 32'(sclk_pin_oe), 32'h0);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic load(input logic [3:0] cfg, input logic [7:0] tx);
    wr(`SSP_IDX_CTRL, 32'h1);
    wr(`SSP_IDX_CFG, {28'h0, cfg});
    wr(`SSP_IDX_DLO, {28'h0, tx[3:0]});
    wr(`SSP_IDX_DHI, {28'h0, tx[7:4]});
  endtask

  task automatic t_master(input logic [1:0] mode, input logic lsb, input logic rise,
                          input logic ien, input logic [7:0] tx, input logic [7:0] prx);
    logic [7:0] got;
    int         falls, hi;
    load({lsb, rise, mode}, tx);
    wr(`SSP_IDX_IEN, {30'h0, ien, 1'b0});
    @(negedge core_clk);
    check("sclk idle", 32'(sclk_pin_o), 32'h0);
    check("sclk oe", 32'(sclk_pin_oe), 32'h1);
    fork
      u_peer.as_slave(prx, lsb, rise, got, falls, hi);
      begin
        wr(`SSP_IDX_CTRL, 32'h3);
        repeat (20) @(posedge core_clk);
        rdc("run", `SSP_IDX_CTRL, 32'h3);
      end
    join
    check("clocks", 32'(falls), 32'h8);
    check("high len", 32'(hi), (mode == 2'b01) ? 32'(2 * HC) : 32'(HC));
    check("tx byte", 32'(got), 32'(tx));
    check("sclk low", 32'(sclk_pin_o), 32'h0);
    check("irq", 32'(transfer_irq), 32'(ien));
    check("ready", 32'(slave_ready_out), 32'h0);
    rdc("rx lo", `SSP_IDX_DLO, {28'h0, prx[3:0]});
    rdc("rx hi", `SSP_IDX_DHI, {28'h0, prx[7:4]});
    rdc("flag", `SSP_IDX_FLAG, 32'h1);
    rdc("flag clr", `SSP_IDX_FLAG, 32'h0);
    rdc("stop", `SSP_IDX_CTRL, 32'h1);
    $display("test master mode %0d done", mode);
  endtask

  task automatic t_slave(input logic lsb, input logic rise, input int nclk,
                         input logic [7:0] tx, input logic [7:0] prx);
    logic [7:0] got;
    load({lsb, rise, 2'b00}, tx);
    wr(`SSP_IDX_CTRL, 32'h3);
    repeat (2) @(negedge core_clk);
    check("ready up", 32'(slave_ready_out), 32'h1);
    check("ready oe", 32'(slave_ready_out_oe), 32'h1);
    check("sclk oe", 32'(sclk_pin_oe), 32'h0);
    u_peer.as_master(prx, lsb, rise, nclk, got);
    check("ready down", 32'(slave_ready_out), 32'h0);
    check("tx byte", 32'(got), 32'(tx));
    rdc("rx lo", `SSP_IDX_DLO, {28'h0, prx[3:0]});
    rdc("rx hi", `SSP_IDX_DHI, {28'h0, prx[7:4]});
    rdc("flag", `SSP_IDX_FLAG, 32'h1);
    rdc("stop", `SSP_IDX_CTRL, 32'h1);
    $display("test slave %0d clocks done", nclk);
  endtask

  // left armed at the end: no clocks follow, so it runs last
  task automatic t_ready_clear();
    load(4'h0, 8'h33);
    wr(`SSP_IDX_CTRL, 32'h3);
    repeat (2) @(negedge core_clk);
    check("ready up", 32'(slave_ready_out), 32'h1);
    rdc("hi nibble", `SSP_IDX_DHI, 32'h3);
    @(negedge core_clk);
    check("ready cleared", 32'(slave_ready_out), 32'h0);
    $display("test ready clear done");
  endtask

  initial
  begin
    errors = 0;
    comparisons = 0;
    cycles = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_master(2'b01, 1'b0, 1'b1, 1'b1, 8'hA5, 8'h3C);
    t_master(2'b10, 1'b1, 1'b0, 1'b0, 8'h96, 8'hE1);
    t_master(2'b11, 1'b0, 1'b0, 1'b1, 8'h0F, 8'hB4);
    t_slave(1'b1, 1'b1, 10, 8'h5A, 8'hC3);
    t_slave(1'b0, 1'b0, 8, 8'h81, 8'h7E);
    t_ready_clear();
    final_report();
  end
endmodule
`default_nettype wire
